// ===== src/osc_ctrl_defs.vh
// Constants for the oscillator control register block
// Operation
// RQ1 - Current source read-only, codes 001/010/011
// RQ2 - Slow internal RC reports code 101
// RQ3 - Unimplemented bits read zero, ignore writes
// RQ4 - New source loads from nonvolatile configuration
// RQ5 - Lock, secondary enable, switch request reset zero
// RQ6 - Codes 000, 100, 110, 111 per source
// RQ7 - Freeze configuration when lock and monitor set; code still accepts secondary enable writes while frozen
// RQ8 - Writes to read-only bits change nothing
`ifndef OSC_CTRL_DEFS_VH
`define OSC_CTRL_DEFS_VH
`define ADDR_OSC_CTRL      4'h0
`define ADDR_IRQ_STATUS    4'h4
`define ADDR_IRQ_MASK      4'h8
`define BIT_SW_REQ         0
`define BIT_SEC_EN         1
`define BIT_FAIL           3
`define BIT_PLL_LOCK       5
`define BIT_FREEZE         7
`define FLD_NEW_LSB        8
`define FLD_CUR_LSB        12
`define OSC_CTRL_WMASK     16'h0783
`define SRC_FRC            3'h0
`define SRC_FRC_PLL        3'h1
`define SRC_PRI            3'h2
`define SRC_PRI_PLL        3'h3
`define SRC_SEC            3'h4
`define SRC_SLOW_RC        3'h5
`define SRC_FRC_DIV16      3'h6
`define SRC_FRC_DIVN       3'h7
`define IRQ_BIT_FAIL       0
`define IRQ_BIT_LOCK_CHG   1
`endif

// ===== src/oscillator_control_register.v
// Oscillator control register with classic Wishbone slave and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_defs.vh"
module oscillator_control_register (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [3:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// Clock system status
	input  wire [2:0]  active_source_i,
	input  wire [2:0]  nv_source_sel_i,
	input  wire        pll_locked_i,
	input  wire        clock_fail_i,
	input  wire        switch_monitor_cfg0_i,
	input  wire        switch_done_i,
	// Controls
	output reg  [2:0]  new_source_sel_o,
	output reg         switch_request_o,
	output reg         secondary_osc_enable_o,
	output reg         config_frozen_o,
	output reg         irq_o
);
	reg  [2:0] current_source_sel_ff;
	reg        pll_lock_ff;
	reg        fail_detect_flag_ff;
	reg        switch_freeze_bit_ff;
	reg  [1:0] irq_status_ff;
	reg  [1:0] irq_mask_ff;
	reg        nv_loaded_ff;
	wire       req;
	wire       wr;
	wire       rd;
	wire [15:0] ctrl_rd;
	wire       frozen;
	wire [1:0] events;
	wire       wr_lo;
	wire       wr_hi;

	assign req   = cyc_i & stb_i & ~ack_o;
	assign wr    = req & we_i;
	assign rd    = req & ~we_i;
	assign wr_lo = wr & sel_i[0] & (adr_i == `ADDR_OSC_CTRL);
	assign wr_hi = wr & sel_i[1] & (adr_i == `ADDR_OSC_CTRL);
	// RQ7 freeze when lock bit and monitor config both set
	assign frozen = switch_freeze_bit_ff & switch_monitor_cfg0_i;
	assign events = {pll_lock_ff ^ pll_locked_i, clock_fail_i & ~fail_detect_flag_ff};

	// RQ3 zero unused bits
	assign ctrl_rd = {1'b0, current_source_sel_ff, 1'b0, new_source_sel_o,
		switch_freeze_bit_ff, 1'b0, pll_lock_ff, 1'b0, fail_detect_flag_ff, 1'b0,
		secondary_osc_enable_o, switch_request_o};

	// RQ1 RQ2 RQ6 status mirror of active source code
	always @(posedge clk_i) begin
		if (rst_i) begin
			current_source_sel_ff <= `SRC_FRC;
			pll_lock_ff           <= 1'b0;
		end else begin
			current_source_sel_ff <= active_source_i;
			pll_lock_ff           <= pll_locked_i;
		end
	end

	// Strap captured under reset and again in the first cycle after reset release
	always @(posedge clk_i) begin
		if (rst_i) begin
			nv_loaded_ff     <= 1'b0;
			// RQ4 configuration value, not a constant
			new_source_sel_o <= nv_source_sel_i;
		end else if (!nv_loaded_ff) begin
			nv_loaded_ff <= 1'b1;
			// RQ4 load from configuration
			new_source_sel_o <= nv_source_sel_i;
		end else if (wr_hi && !frozen) begin
			new_source_sel_o <= dat_i[`FLD_NEW_LSB+2:`FLD_NEW_LSB];
		end
	end

	// RQ5 writable bits reset zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			switch_freeze_bit_ff   <= 1'b0;
			secondary_osc_enable_o <= 1'b0;
			switch_request_o       <= 1'b0;
		end else begin
			if (wr_lo) begin
				// Lock is sticky once set with monitor enabled
				if (!frozen)
					switch_freeze_bit_ff <= dat_i[`BIT_FREEZE];
				secondary_osc_enable_o <= dat_i[`BIT_SEC_EN];
			end
			// Completion wins over a software write
			if (switch_done_i)
				switch_request_o <= 1'b0;
			else if (wr_lo && !frozen)
				switch_request_o <= dat_i[`BIT_SW_REQ];
		end
	end

	// RQ8 fail flag set by hardware, software clears only
	always @(posedge clk_i) begin
		if (rst_i)
			fail_detect_flag_ff <= 1'b0;
		else if (clock_fail_i)
			fail_detect_flag_ff <= 1'b1;
		else if (wr_lo && !dat_i[`BIT_FAIL])
			fail_detect_flag_ff <= 1'b0;
	end

	// Interrupt status: set wins over read clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_ff <= 2'h0;
			irq_mask_ff   <= 2'h0;
		end else begin
			if (rd && adr_i == `ADDR_IRQ_STATUS)
				irq_status_ff <= events;
			else
				irq_status_ff <= irq_status_ff | events;
			if (wr && sel_i[0] && adr_i == `ADDR_IRQ_MASK)
				irq_mask_ff <= dat_i[1:0];
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_o           <= 1'b0;
			config_frozen_o <= 1'b0;
		end else begin
			irq_o           <= |(irq_status_ff & irq_mask_ff);
			config_frozen_o <= frozen;
		end
	end

	// Bus answer one cycle after request
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= req;
			dat_o <= 32'h0;
			if (rd) begin
				if (adr_i == `ADDR_OSC_CTRL)
					dat_o <= {16'h0, ctrl_rd};
				else if (adr_i == `ADDR_IRQ_STATUS)
					dat_o <= {30'h0, irq_status_ff};
				else if (adr_i == `ADDR_IRQ_MASK)
					dat_o <= {30'h0, irq_mask_ff};
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/osc_ctrl_assertions.sv
// Checker for the oscillator control register
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_chk (
	input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
	input wire logic        switch_monitor_cfg0_i, switch_request_o, secondary_osc_enable_o, config_frozen_o,
	input wire logic [3:0]  adr_i, sel_i,
	input wire logic [31:0] dat_i, dat_o,
	input wire logic [2:0]  active_source_i, nv_source_sel_i, new_source_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = cyc_i && stb_i && !ack_o;
	a_ack_one: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_ack_resp: assert property (req |=> ack_o) else $error("no ack");
	a_cur_src: assert property (ack_o && $past(!we_i && adr_i == 4'h0) |->
		dat_o[14:12] == $past(active_source_i, 2)) else $error("current source");
	a_unimpl_zero: assert property (ack_o |-> (dat_o & 32'hffff8854) == 0) else $error("unused bit");
	a_nv_load: assert property ($fell(rst_i) |=> new_source_sel_o == $past(nv_source_sel_i))
		else $error("new source load");
	a_reset_zero: assert property ($fell(rst_i) |->
		!switch_request_o && !secondary_osc_enable_o && !config_frozen_o) else $error("reset value");
	a_freeze_hold: assert property (config_frozen_o && switch_monitor_cfg0_i |=> $stable(new_source_sel_o))
		else $error("frozen changed");
	a_sec_write: assert property (req && we_i && adr_i == 4'h0 && sel_i[0] |=>
		secondary_osc_enable_o == $past(dat_i[1])) else $error("enable write");
	cover property (req && we_i && config_frozen_o);
	cover property ($rose(config_frozen_o));
	cover property (req && !we_i && adr_i == 4'h0);
endmodule
`default_nettype wire

// ===== testbench/oscillator_control_register_tb.sv
// Bench for the oscillator control register
`timescale 1ns/1ps
`default_nettype none
module oscillator_control_register_tb;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pll = 0, cf = 0, mon = 0;
	logic        ack_o, sw, sec, frz, irq_o;
	logic [3:0]  adr_i = 0, sel_i = 4'hf;
	logic [31:0] dat_i = 0, dat_o, rd, r = 32'h969ca49b;
	logic [2:0]  act = 0, nv = 3'h6, ns;
	int          n_fail = 0, tests_run = 0, k;
	oscillator_control_register u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .active_source_i(act), .nv_source_sel_i(nv), .pll_locked_i(pll), .clock_fail_i(cf),
		.switch_monitor_cfg0_i(mon), .switch_done_i(1'b0), .new_source_sel_o(ns), .switch_request_o(sw),
		.secondary_osc_enable_o(sec), .config_frozen_o(frz), .irq_o);
	initial forever #25 clk_i = ~clk_i;
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] ex(logic [15:0] d);
		return {17'h0, act, 1'b0, d[10:7], 1'b0, pll, 3'h0, d[1:0]};
	endfunction
	task automatic chk(logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Bounded wait so a missing ack ends the run
	task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
		k = 0;
		@(posedge clk_i) {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i) k++; while (ack_o !== 1'b1 && k < 20);
		rd = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		if (k >= 20) begin
			chk(0, 1);
			end_sim();
		end
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		repeat (2) @(posedge clk_i);
		wb(0, 4'h0, 0); chk(rd, ex({5'h0, nv, 8'h0}));
		for (int i = 0; i < 8; i++) begin
			act <= i[2:0];
			wb(0, 4'h0, 0); chk(rd[14:12], i);
		end
		$display("source codes done");
		repeat (20) begin
			r = lfsr(r);
			pll <= r[20];
			wb(1, 4'h0, r & ~32'h88);
			wb(0, 4'h0, 0); chk(rd, ex(r[15:0] & ~16'h88));
			chk(ns, r[10:8]);
		end
		$display("random writes done");
		mon <= 1;
		wb(1, 4'h0, 32'h280);
		wb(1, 4'h0, 32'h500);
		wb(0, 4'h0, 0); chk(rd[10:7], 4'h5);
		chk(frz, 1);
		mon <= 0;
		wb(1, 4'h0, 32'h300);
		wb(0, 4'h0, 0); chk(rd[10:7], 4'h6);
		$display("freeze done");
		wb(0, 4'h4, 0);
		wb(1, 4'h8, 32'h2);
		chk(irq_o, 0);
		pll <= ~pll;
		repeat (4) @(posedge clk_i);
		chk(irq_o, 1);
		wb(0, 4'h4, 0); chk(rd, 2);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 0);
		wb(0, 4'hc, 0); chk(rd, 0);
		$display("interrupt done");
		cf <= 1;
		@(posedge clk_i) cf <= 0;
		wb(0, 4'h0, 0); chk(rd[3], 1);
		wb(0, 4'h4, 0); chk(rd, 1);
		wb(1, 4'h0, 32'h300);
		wb(0, 4'h0, 0); chk(rd[3], 0);
		$display("fail flag done");
		end_sim();
	end
endmodule
bind oscillator_control_register osc_ctrl_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o,
	.switch_monitor_cfg0_i, .switch_request_o, .secondary_osc_enable_o, .config_frozen_o, .adr_i, .sel_i,
	.dat_i, .dat_o, .active_source_i, .nv_source_sel_i, .new_source_sel_o);
`default_nettype wire
